/* design/smps_pkg.sv */
package smps_pkg;
  localparam int INSTR_W = 24;
  localparam int RESP_W = 17;
  localparam int STATUS_W = 16;
  localparam int SCAN_W = 32;
  localparam int DIV_HALF = 4;
  localparam logic [2:0] OP_NO_OPERATION_CMD = 3'h0;
  localparam logic [2:0] OP_LOOPBACK = 3'h1;
  localparam logic [2:0] OP_REG_STORE = 3'h2;
  localparam logic [2:0] OP_REG_FETCH = 3'h3;
  localparam logic [2:0] OP_TRIGGER = 3'h4;
  localparam logic [2:0] OP_RESET = 3'h5;
  localparam logic [2:0] OP_FLAG_FETCH = 3'h6;
  localparam logic [2:0] OP_DRIVER_GATE = 3'h7;
  localparam int OP_MSB = 23;
  localparam int OP_LSB = 21;
  localparam int PAR_BIT = 0;
  localparam int DATA_MSB = 16;
  localparam int DATA_LSB = 1;
  localparam int COVER_16 = 16;
  localparam int COVER_24 = 24;
  localparam int COVER_8 = 8;
  localparam int STAT_PARITY_ERR = 0;
  localparam int TRIG_SEL_BIT = 0;
  localparam int TRIG_STOP_BIT = 1;
  localparam int GATE_EN_BIT = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
endpackage

/* design/smps_if.sv */
`timescale 1ns/1ns
interface smps_if;
  logic serial_shift_clock;
  logic access_mode_pin;
  logic chain_select_n;
  logic serial_in;
  logic serial_out;
  modport ctrl (
    output serial_shift_clock,
    output access_mode_pin,
    output chain_select_n,
    output serial_in,
    input serial_out
  );
  modport dev (
    input serial_shift_clock,
    input access_mode_pin,
    input chain_select_n,
    input serial_in,
    output serial_out
  );
endinterface

/* design/smps_device.sv */
`timescale 1ns/1ns
module smps_device (
  input wire logic clk,
  input wire logic rst,
  smps_if.dev port,
  input wire logic [15:0] reg_fetch_data,
  input wire logic [smps_pkg::SCAN_W-1:0] core_scan_q,
  output logic [smps_pkg::SCAN_W-1:0] core_scan_d,
  output logic core_scan_load,
  output logic sys_clock_stop,
  output logic driver_enable,
  output logic core_reset_pulse,
  output logic reg_store_pulse,
  output logic [23:0] reg_store_word,
  output logic [15:0] status_view
);
  logic sclk_s1, sclk_s2, sclk_s3;
  logic sel_s1, sel_s2, sel_s3;
  logic mode_s1, mode_s2;
  logic din_s1, din_s2;
  logic [smps_pkg::INSTR_W-1:0] instr_reg;
  logic [smps_pkg::SCAN_W-1:0] scan_reg;
  logic bypass_reg;
  logic scan_sel_reg;
  logic exec_pending_reg;
  logic [15:0] status_reg;
  logic stop_reg, gate_reg, rst_pulse_reg, store_pulse_reg;
  logic trig_apply_reg, sel_hold_reg;
  logic [23:0] store_word_reg;
  logic dout_reg;

  wire sclk_rise = sclk_s2 && !sclk_s3;
  wire sel_active = !sel_s2;
  wire sel_release = sel_s2 && !sel_s3;
  wire instr_shift = sclk_rise && sel_active && !mode_s2;
  wire scan_shift = sclk_rise && sel_active && mode_s2;
  wire scan_frame = sel_active && mode_s2;
  wire [2:0] opcode = instr_reg[smps_pkg::OP_MSB:smps_pkg::OP_LSB];
  // Bits enter at the top, so a short instruction lands in the MSBs
  wire cover8 = (opcode == smps_pkg::OP_REG_FETCH) || (opcode == smps_pkg::OP_RESET)
    || (opcode == smps_pkg::OP_FLAG_FETCH);
  wire cover16 = (opcode == smps_pkg::OP_NO_OPERATION_CMD);
  wire [23:0] cover_mask = cover8 ? 24'hff0000 : (cover16 ? 24'hffff00 : 24'hffffff);
  // Parity bit is the lowest covered bit; odd parity over covered bits
  wire parity_ok = ^(instr_reg & cover_mask);
  wire [15:0] payload = instr_reg[smps_pkg::DATA_MSB:smps_pkg::DATA_LSB];
  wire [15:0] resp_data = (opcode == smps_pkg::OP_REG_FETCH) ? reg_fetch_data :
    (opcode == smps_pkg::OP_FLAG_FETCH) ? status_reg :
    (opcode == smps_pkg::OP_NO_OPERATION_CMD) ? status_reg : payload;
  wire resp_load = exec_pending_reg && parity_ok;
  wire trig_exec = resp_load && (opcode == smps_pkg::OP_TRIGGER);
  wire store_exec = resp_load && (opcode == smps_pkg::OP_REG_STORE);
  wire reset_exec = resp_load && (opcode == smps_pkg::OP_RESET);
  wire gate_exec = resp_load && (opcode == smps_pkg::OP_DRIVER_GATE);
  wire flag_exec = resp_load && (opcode == smps_pkg::OP_FLAG_FETCH);
  // Data LSB leaves first and the parity bit last
  wire [16:0] resp_word = {~^resp_data, resp_data};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {sel_s1, sel_s2, sel_s3} <= 3'h7;
      {mode_s1, mode_s2, din_s1, din_s2} <= 4'h0;
    end else begin
      sclk_s1 <= port.serial_shift_clock;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sel_s1 <= port.chain_select_n;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      mode_s1 <= port.access_mode_pin;
      mode_s2 <= mode_s1;
      din_s1 <= port.serial_in;
      din_s2 <= din_s1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exec_pending_reg <= 1'b0;
    end else begin
      exec_pending_reg <= sel_release && !mode_s2;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_reg <= 24'h000000;
    end else if (instr_shift) begin
      instr_reg <= {din_s2, instr_reg[23:1]};
    end else if (resp_load) begin
      // Opcode bits stay, so a trigger remains loaded through a scan frame
      instr_reg <= {instr_reg[23:17], resp_word};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= smps_pkg::STATUS_RESET;
    end else if (exec_pending_reg && !parity_ok) begin
      status_reg[smps_pkg::STAT_PARITY_ERR] <= 1'b1;
    end else if (flag_exec) begin
      status_reg <= smps_pkg::STATUS_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_reg <= 1'b1;
      rst_pulse_reg <= 1'b0;
      store_pulse_reg <= 1'b0;
    end else begin
      rst_pulse_reg <= reset_exec;
      store_pulse_reg <= store_exec;
      if (gate_exec) begin
        gate_reg <= payload[smps_pkg::GATE_EN_BIT];
      end
    end
  end

  // Clock control acts first; the string switches a cycle later, so the
  // scan path switches under a stopped core only when the same trigger sets the stop bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_reg <= 1'b0;
      sel_hold_reg <= 1'b0;
      trig_apply_reg <= 1'b0;
      scan_sel_reg <= 1'b0;
    end else begin
      trig_apply_reg <= trig_exec;
      if (trig_exec) begin
        stop_reg <= payload[smps_pkg::TRIG_STOP_BIT];
        sel_hold_reg <= payload[smps_pkg::TRIG_SEL_BIT];
      end
      if (trig_apply_reg) begin
        scan_sel_reg <= sel_hold_reg;
      end
    end
  end

  // The instruction register takes the response, so the stored word is kept apart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      store_word_reg <= 24'h000000;
    end else if (store_exec) begin
      store_word_reg <= instr_reg;
    end
  end

  // Internal string excludes this port's own latches; boundary chain absent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_reg <= 32'h00000000;
      bypass_reg <= 1'b0;
    end else if (scan_shift) begin
      if (scan_sel_reg) begin
        bypass_reg <= din_s2;
      end else begin
        scan_reg <= {din_s2, scan_reg[31:1]};
      end
    end else if (!scan_frame) begin
      // Capture only outside a scan frame, or shifted data would be overwritten
      scan_reg <= core_scan_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_reg <= 1'b0;
    end else if (mode_s2) begin
      dout_reg <= scan_sel_reg ? bypass_reg : scan_reg[0];
    end else begin
      dout_reg <= instr_reg[0];
    end
  end

  assign port.serial_out = dout_reg;
  assign core_scan_d = scan_reg;
  assign core_scan_load = scan_shift && !scan_sel_reg;
  assign sys_clock_stop = stop_reg;
  assign driver_enable = gate_reg;
  assign core_reset_pulse = rst_pulse_reg;
  assign reg_store_pulse = store_pulse_reg;
  assign reg_store_word = store_word_reg;
  assign status_view = status_reg;
endmodule

/* design/smps_controller.sv */
`timescale 1ns/1ns
module smps_controller (
  input wire logic clk,
  input wire logic rst,
  smps_if.ctrl port,
  input wire logic start,
  input wire logic scan_mode,
  input wire logic [5:0] bit_count,
  input wire logic [31:0] tx_word,
  output logic busy,
  output logic done,
  output logic [31:0] rx_word
);
  typedef enum logic [1:0] {
    SMPS_IDLE = 2'b00,
    SMPS_SHIFT = 2'b01,
    SMPS_END = 2'b10
  } smps_state_e;
  smps_state_e state_reg;
  logic [31:0] tx_reg, rx_reg;
  logic [5:0] left_reg;
  logic [3:0] div_reg;
  logic sclk_reg, sel_n_reg, mode_reg, done_reg;
  logic rx_s1, rx_s2;

  wire div_wrap = (div_reg == 4'(smps_pkg::DIV_HALF - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
    end else begin
      rx_s1 <= port.serial_out;
      rx_s2 <= rx_s1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SMPS_IDLE;
      tx_reg <= 32'h00000000;
      rx_reg <= 32'h00000000;
      left_reg <= 6'h00;
      div_reg <= 4'h0;
      sclk_reg <= 1'b0;
      sel_n_reg <= 1'b1;
      mode_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        SMPS_IDLE: begin
          if (start && bit_count != 6'h00) begin
            tx_reg <= tx_word;
            left_reg <= bit_count;
            mode_reg <= scan_mode;
            sel_n_reg <= 1'b0;
            div_reg <= 4'h0;
            state_reg <= SMPS_SHIFT;
          end
        end
        SMPS_SHIFT: begin
          div_reg <= div_wrap ? 4'h0 : div_reg + 4'h1;
          if (div_wrap) begin
            sclk_reg <= !sclk_reg;
            if (sclk_reg) begin
              tx_reg <= {1'b0, tx_reg[31:1]};
              rx_reg <= {rx_s2, rx_reg[31:1]};
              left_reg <= left_reg - 6'h01;
              if (left_reg == 6'h01) begin
                state_reg <= SMPS_END;
              end
            end
          end
        end
        SMPS_END: begin
          sel_n_reg <= 1'b1;
          done_reg <= 1'b1;
          state_reg <= SMPS_IDLE;
        end
        default: state_reg <= SMPS_IDLE;
      endcase
    end
  end

  assign port.serial_shift_clock = sclk_reg;
  assign port.chain_select_n = sel_n_reg;
  assign port.access_mode_pin = mode_reg;
  assign port.serial_in = tx_reg[0];
  assign busy = (state_reg != SMPS_IDLE);
  assign done = done_reg;
  assign rx_word = rx_reg;
endmodule

/* verification/smps_sva.sv */
`timescale 1ns/1ns
module smps_sva (
  input logic clk,
  input logic rst,
  input logic serial_shift_clock,
  input logic access_mode_pin,
  input logic chain_select_n,
  input logic serial_in,
  input logic serial_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_high;
    serial_shift_clock[*4] ##1 !serial_shift_clock;
  endsequence
  sequence s_low;
    (!serial_shift_clock)[*4];
  endsequence
  property p_idle_still;
    chain_select_n |-> !serial_shift_clock;
  endproperty
  a_idle_still: assert property (p_idle_still)
    else $error("shift clock moved while deselected");
  property p_high_len;
    $rose(serial_shift_clock) |-> s_high;
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("shift clock high phase wrong length");
  property p_low_len;
    $fell(serial_shift_clock) && !chain_select_n |-> s_low;
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("shift clock low phase too short");
  property p_mode_hold;
    !chain_select_n && !$past(chain_select_n) |-> $stable(access_mode_pin);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed inside a frame");
  property p_din_hold;
    serial_shift_clock && $past(serial_shift_clock) |-> $stable(serial_in);
  endproperty
  a_din_hold: assert property (p_din_hold)
    else $error("serial input moved while shift clock high");
  property p_sel_rise;
    $rose(chain_select_n) |-> !serial_shift_clock;
  endproperty
  a_sel_rise: assert property (p_sel_rise)
    else $error("frame ended with shift clock high");
  property p_sel_min;
    $fell(chain_select_n) |-> (!chain_select_n)[*8];
  endproperty
  a_sel_min: assert property (p_sel_min)
    else $error("frame shorter than one bit");
  property p_out_hold;
    chain_select_n && $past(chain_select_n, 8) |-> $stable(serial_out);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("serial output moved while idle");
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic clk, rst, start, scan_mode, done, busy;
  logic [5:0] bit_count;
  logic [31:0] tx_word, rx_word;
  logic drv_en, clk_stop, st_pulse, rs_pulse;
  logic [23:0] st_word, st_seen, w_last;
  logic [15:0] status_view;
  int err_total = 0, checks = 0, stores = 0, resets = 0, n;
  smps_if link();
  smps_controller smps_controller_i (.clk(clk), .rst(rst), .port(link), .start(start),
    .scan_mode(scan_mode), .bit_count(bit_count), .tx_word(tx_word), .busy(busy),
    .done(done), .rx_word(rx_word));
  smps_device smps_device_i (.clk(clk), .rst(rst), .port(link),
    .reg_fetch_data(16'h5a3c), .core_scan_q(32'h0f0f_1234), .core_scan_d(),
    .core_scan_load(), .sys_clock_stop(clk_stop), .driver_enable(drv_en),
    .core_reset_pulse(rs_pulse), .reg_store_pulse(st_pulse),
    .reg_store_word(st_word), .status_view(status_view));
  smps_sva smps_sva_i (.clk(clk), .rst(rst), .serial_shift_clock(link.serial_shift_clock),
    .access_mode_pin(link.access_mode_pin), .chain_select_n(link.chain_select_n),
    .serial_in(link.serial_in), .serial_out(link.serial_out));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (st_pulse) begin
      stores++;
      st_seen = st_word;
    end
    if (rs_pulse) resets++;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic xfer(input logic scan, input logic [5:0] nb, input logic [31:0] tx);
    int k;
    start = 1'b1;
    scan_mode = scan;
    bit_count = nb;
    tx_word = tx;
    @(negedge clk);
    start = 1'b0;
    for (k = 0; k < 3000; k++) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    if (k == 3000) begin
      err_total++;
      final_report;
    end
    // Device acts four clocks after the frame closes
    repeat (6) @(negedge clk);
  endtask
  // Odd parity over the top cw bits, parity in the lowest covered bit
  task automatic send(input logic [2:0] op, input logic [20:0] pl, input int cw,
    input logic bad);
    int s;
    s = 24 - cw;
    w_last = {op, pl};
    w_last[s] = 1'b0;
    w_last[s] = ~(^(w_last >> s)) ^ bad;
    xfer(1'b0, 6'(cw), 32'(w_last >> s));
    $display("test op %0d width %0d bad %0d done", op, cw, bad);
  endtask
  initial begin
    clk = 0; rst = 1; start = 0; scan_mode = 0; bit_count = 0; tx_word = 0;
    repeat (3) @(negedge clk);
    rst = 0;
    @(negedge clk);
    `CHK("drv_en", 1'b1, drv_en)
    send(smps_pkg::OP_DRIVER_GATE, 21'h0, 24, 1'b0);
    `CHK("drv_en", 1'b0, drv_en)
    send(smps_pkg::OP_DRIVER_GATE, 21'h10000, 24, 1'b1);
    `CHK("drv_en", 1'b0, drv_en)
    `CHK("perr", 1'b1, status_view[0])
    n = stores;
    send(smps_pkg::OP_REG_STORE, 21'h12345, 24, 1'b1);
    `CHK("stores", n, stores)
    send(smps_pkg::OP_FLAG_FETCH, 21'h0, 8, 1'b0);
    `CHK("perr", 1'b0, status_view[0])
    send(smps_pkg::OP_REG_STORE, 21'h0abcd, 24, 1'b0);
    `CHK("stores", n + 1, stores)
    `CHK("st_word", w_last, st_seen)
    n = resets;
    send(smps_pkg::OP_RESET, 21'h0, 8, 1'b0);
    `CHK("resets", n + 1, resets)
    send(smps_pkg::OP_REG_FETCH, 21'h0, 8, 1'b0);
    send(smps_pkg::OP_NO_OPERATION_CMD, 21'h0, 16, 1'b0);
    `CHK("fetch_resp", 16'h5a3c, rx_word[31:16])
    `CHK("perr", 1'b0, status_view[0])
    send(smps_pkg::OP_NO_OPERATION_CMD, 21'h0, 16, 1'b1);
    `CHK("perr", 1'b1, status_view[0])
    send(smps_pkg::OP_LOOPBACK, 21'h0acf0, 24, 1'b0);
    send(smps_pkg::OP_LOOPBACK, 21'h0, 24, 1'b0);
    `CHK("echo_resp", ({~^16'h5678, 16'h5678}), rx_word[24:8])
    send(smps_pkg::OP_TRIGGER, 21'h4, 24, 1'b0);
    `CHK("clk_stop", 1'b1, clk_stop)
    xfer(1'b1, 6'd32, 32'h0000_0000);
    `CHK("int_scan", 32'h0f0f_1234, rx_word)
    $display("test internal scan done");
    send(smps_pkg::OP_TRIGGER, 21'h6, 24, 1'b0);
    `CHK("clk_stop", 1'b1, clk_stop)
    xfer(1'b1, 6'd8, 32'h0000_00b5);
    `CHK("bypass", 7'h35, rx_word[31:25])
    $display("test bypass scan done");
    final_report;
  end
endmodule
